// file: common/cic_pkg.sv
// constants of the component input control block
// assumes one 125 MHz clock and byte wide subaddressed register access
package cic_pkg;
    // -----------------------------------------------------------------
    // subaddresses
    // -----------------------------------------------------------------
    localparam logic [7:0] CIC_ADDR_AICTRL = 8'h23;
    localparam logic [7:0] CIC_ADDR_GAIN3  = 8'h24;
    localparam logic [7:0] CIC_ADDR_GAIN4  = 8'h25;
    localparam logic [7:0] CIC_ADDR_DSW    = 8'h29;

    // -----------------------------------------------------------------
    // analog input control fields
    // -----------------------------------------------------------------
    localparam int CIC_PORT_EN_BIT  = 6;
    localparam int CIC_CLK_SEL_BIT  = 5;
    localparam int CIC_REF_SEL_BIT  = 4;
    localparam int CIC_SWIND_BIT    = 2;
    localparam int CIC_G4_MSB_BIT   = 1;
    localparam int CIC_G3_MSB_BIT   = 0;
    localparam logic [7:0] CIC_AICTRL_RMASK = 8'hF7;

    // -----------------------------------------------------------------
    // delay / fast switch fields
    // -----------------------------------------------------------------
    localparam int CIC_FSW_EN_BIT  = 7;
    localparam int CIC_FSW_POL_BIT = 6;
    localparam int CIC_FSW_DL_HI   = 5;
    localparam int CIC_FSW_DL_LO   = 4;
    localparam int CIC_PEAK_BIT    = 3;
    localparam int CIC_CPDL_HI     = 2;
    localparam int CIC_CPDL_LO     = 0;

    // -----------------------------------------------------------------
    // reset values and delay line geometry
    // -----------------------------------------------------------------
    localparam logic [7:0] CIC_RST_AICTRL = 8'h00;
    localparam logic [7:0] CIC_RST_GAIN   = 8'h00;
    localparam logic [7:0] CIC_RST_DSW    = 8'h00;
    localparam int         CIC_DLY_AW     = 5;
    localparam logic [6:0] CIC_DLY_BASE   = 7'h12;
    localparam logic [6:0] CIC_CPDL_STEP  = 7'h04;
endpackage

// file: common/cic_dly_if.sv
// carrier between the top and one pixel delay line
// assumes the top drives the write side and the memory answers rdata
interface cic_dly_if #(
    parameter int W  = 8,
    parameter int AW = 5
);
    logic          adv;
    logic [W-1:0]  wdata;
    logic [AW-1:0] delay;
    logic [W-1:0]  rdata;

    modport src (output adv, output wdata, output delay, input rdata);
    modport mem (input adv, input wdata, input delay, output rdata);
endinterface

// file: hw/cic_delay_mem.sv
// circular pixel store giving a programmable delay of delay+1 samples
// assumes adv marks one pixel; rdata is registered, one cycle after adv
module cic_delay_mem
    import cic_pkg::*;
#(
    parameter int W  = 8,
    parameter int AW = CIC_DLY_AW
) (
    input  wire logic clk,
    input  wire logic rst,
    cic_dly_if.mem    dl
);
    logic [W-1:0]  mem_q [2**AW];
    logic [AW-1:0] ptr_q;
    logic [AW-1:0] ptr_d;
    logic [AW-1:0] rd_addr;
    logic [W-1:0]  rd_q;
    logic [W-1:0]  rd_d;

    // read before write, so delay all ones returns the slot being replaced
    always_comb begin
        rd_addr = ptr_q - AW'(1) - dl.delay;
        ptr_d   = dl.adv ? ptr_q + AW'(1) : ptr_q;
        rd_d    = dl.adv ? mem_q[rd_addr] : rd_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ptr_q <= '0;
            rd_q  <= '0;
        end else begin
            ptr_q <= ptr_d;
            rd_q  <= rd_d;
        end
    end

    always_ff @(posedge clk) begin
        if (dl.adv) begin
            mem_q[ptr_q] <= dl.wdata;
        end
    end

    assign dl.rdata = rd_q;
endmodule

// file: hw/cic_top.sv
// component input control: register bank, AD port, gain loop reset,
// pixel fast switch with delay trim and component luma peaking
// assumes synchronous inputs and a decoded subaddress byte access port
// What this block does
// - port enable low puts AD port tristate
// - clock select picks line-locked or external clock
// - reference bit overrides line-noise clamp setting
// - switch indicator edge resets gain loop
// - channel 3 gain nine bits, msb 23h[0]
// - channel 4 gain nine bits, msb 23h[1]
// - fast switch enable selects pixelwise source
// - polarity bit inverts fast switch mapping
// - polarity bit is static source when disabled
// - two-bit fast switch delay trim
// - peaking bit enables component luma boost
// - component delay in four-pixel steps
module cic_top
    import cic_pkg::*;
#(
    parameter int PIX_W = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             reg_wr_en,
    input  wire logic             reg_rd_en,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    output logic      [7:0]       reg_rdata,
    input  wire logic [PIX_W-1:0] adc_sample,
    output logic      [PIX_W-1:0] ad_port_out,
    output logic                  ad_port_oe,
    output logic                  converter_clock_sel,
    output logic                  clamp_reference_sel,
    input  wire logic             line_noise_clamp_setting,
    output logic                  clamp_follow_noise,
    input  wire logic             source_switch_indicator,
    output logic                  gain_loop_reset,
    output logic      [8:0]       static_gain_ch3,
    output logic      [8:0]       static_gain_ch4,
    input  wire logic             pix_valid,
    input  wire logic [PIX_W-1:0] cvbs_pix,
    input  wire logic [PIX_W-1:0] comp_pix,
    input  wire logic             fast_switch_input,
    output logic      [PIX_W-1:0] out_pix,
    output logic                  out_valid,
    output logic                  out_is_comp
);
    // -----------------------------------------------------------------
    // register bank
    // -----------------------------------------------------------------
    logic [7:0] ctrl_q, ctrl_d, g3_q, g3_d, g4_q, g4_d, dsw_q, dsw_d;
    logic [7:0] rdata_q, rdata_d;

    always_comb begin
        ctrl_d  = ctrl_q;
        g3_d    = g3_q;
        g4_d    = g4_q;
        dsw_d   = dsw_q;
        rdata_d = rdata_q;
        if (reg_wr_en) begin
            unique case (reg_addr)
                CIC_ADDR_AICTRL: ctrl_d = reg_wdata & CIC_AICTRL_RMASK;
                CIC_ADDR_GAIN3:  g3_d   = reg_wdata;
                CIC_ADDR_GAIN4:  g4_d   = reg_wdata;
                CIC_ADDR_DSW:    dsw_d  = reg_wdata;
                default:         ;
            endcase
        end
        if (reg_rd_en) begin
            unique case (reg_addr)
                CIC_ADDR_AICTRL: rdata_d = ctrl_q;
                CIC_ADDR_GAIN3:  rdata_d = g3_q;
                CIC_ADDR_GAIN4:  rdata_d = g4_q;
                CIC_ADDR_DSW:    rdata_d = dsw_q;
                default:         rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q  <= CIC_RST_AICTRL;
            g3_q    <= CIC_RST_GAIN;
            g4_q    <= CIC_RST_GAIN;
            dsw_q   <= CIC_RST_DSW;
            rdata_q <= 8'h00;
        end else begin
            ctrl_q  <= ctrl_d;
            g3_q    <= g3_d;
            g4_q    <= g4_d;
            dsw_q   <= dsw_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // -----------------------------------------------------------------
    // static controls
    // -----------------------------------------------------------------
    // AD port drive
    assign ad_port_oe = ctrl_q[CIC_PORT_EN_BIT];
    assign converter_clock_sel = ctrl_q[CIC_CLK_SEL_BIT];
    assign clamp_reference_sel = ctrl_q[CIC_REF_SEL_BIT];
    assign clamp_follow_noise  = ~ctrl_q[CIC_REF_SEL_BIT]
                               & line_noise_clamp_setting;
    assign static_gain_ch3 = {ctrl_q[CIC_G3_MSB_BIT], g3_q};
    assign static_gain_ch4 = {ctrl_q[CIC_G4_MSB_BIT], g4_q};

    // -----------------------------------------------------------------
    // AD port and switch indicator
    // -----------------------------------------------------------------
    logic [PIX_W-1:0] adp_q, adp_d;
    logic             sw_prev_q, sw_prev_d, sw_seen_q, glr_q, glr_d;

    // the first sample only primes the history, so no false edge at reset
    always_comb begin
        adp_d     = adc_sample;
        sw_prev_d = source_switch_indicator;
        glr_d = ctrl_q[CIC_SWIND_BIT] & sw_seen_q
              & (source_switch_indicator ^ sw_prev_q);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            adp_q     <= '0;
            sw_prev_q <= 1'b0;
            sw_seen_q <= 1'b0;
            glr_q     <= 1'b0;
        end else begin
            adp_q     <= adp_d;
            sw_prev_q <= sw_prev_d;
            sw_seen_q <= 1'b1;
            glr_q     <= glr_d;
        end
    end

    assign ad_port_out     = adp_q;
    assign gain_loop_reset = glr_q;

    // -----------------------------------------------------------------
    // delay lines: every path carries a common base so trims stay >= 0
    // -----------------------------------------------------------------
    logic [6:0] comp_dly, fsw_dly;
    // component shift in steps of four
    assign comp_dly = CIC_DLY_BASE + CIC_CPDL_STEP
        * {{4{dsw_q[CIC_CPDL_HI]}}, dsw_q[CIC_CPDL_HI:CIC_CPDL_LO]};
    assign fsw_dly = comp_dly
        + {{5{dsw_q[CIC_FSW_DL_HI]}}, dsw_q[CIC_FSW_DL_HI:CIC_FSW_DL_LO]};

    cic_dly_if #(.W(PIX_W), .AW(CIC_DLY_AW)) cv_if ();
    cic_dly_if #(.W(PIX_W), .AW(CIC_DLY_AW)) cp_if ();
    cic_dly_if #(.W(1),     .AW(CIC_DLY_AW)) fs_if ();

    assign cv_if.adv   = pix_valid;
    assign cv_if.wdata = cvbs_pix;
    assign cv_if.delay = CIC_DLY_BASE[CIC_DLY_AW-1:0];
    assign cp_if.adv   = pix_valid;
    assign cp_if.wdata = comp_pix;
    assign cp_if.delay = comp_dly[CIC_DLY_AW-1:0];
    assign fs_if.adv   = pix_valid;
    assign fs_if.wdata = fast_switch_input;
    assign fs_if.delay = fsw_dly[CIC_DLY_AW-1:0];

    cic_delay_mem #(.W(PIX_W), .AW(CIC_DLY_AW)) u_cv (
        .clk (clk), .rst (rst), .dl (cv_if.mem));
    cic_delay_mem #(.W(PIX_W), .AW(CIC_DLY_AW)) u_cp (
        .clk (clk), .rst (rst), .dl (cp_if.mem));
    cic_delay_mem #(.W(1), .AW(CIC_DLY_AW)) u_fs (
        .clk (clk), .rst (rst), .dl (fs_if.mem));

    // -----------------------------------------------------------------
    // peaking and source selection
    // -----------------------------------------------------------------
    logic             v1_q, ov_q, oc_q, oc_d;
    logic [PIX_W-1:0] yprev_q, yprev_d, opix_q, opix_d, ypk;
    logic [PIX_W+1:0] ysum;

    // a first difference boost; cheap, and close to the wanted lift
    always_comb begin
        ysum = {2'b00, cp_if.rdata}
             + {{2{1'b0}}, cp_if.rdata} / (PIX_W + 2)'(4)
             - {2'b00, yprev_q} / (PIX_W + 2)'(4);
        if (ysum[PIX_W+1]) begin
            ypk = '0;
        end else if (ysum[PIX_W]) begin
            ypk = '1;
        end else begin
            ypk = ysum[PIX_W-1:0];
        end
        yprev_d = v1_q ? cp_if.rdata : yprev_q;
        if (dsw_q[CIC_FSW_EN_BIT]) begin
            oc_d = fs_if.rdata[0] ^ dsw_q[CIC_FSW_POL_BIT];
        end else begin
            oc_d = dsw_q[CIC_FSW_POL_BIT];
        end
        // peaking only on the component path
        if (!v1_q) begin
            opix_d = opix_q;
            oc_d   = oc_q;
        end else if (!oc_d) begin
            opix_d = cv_if.rdata;
        end else if (dsw_q[CIC_PEAK_BIT]) begin
            opix_d = ypk;
        end else begin
            opix_d = cp_if.rdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            v1_q    <= 1'b0;
            ov_q    <= 1'b0;
            oc_q    <= 1'b0;
            yprev_q <= '0;
            opix_q  <= '0;
        end else begin
            v1_q    <= pix_valid;
            ov_q    <= v1_q;
            oc_q    <= oc_d;
            yprev_q <= yprev_d;
            opix_q  <= opix_d;
        end
    end

    assign out_pix     = opix_q;
    assign out_valid   = ov_q;
    assign out_is_comp = oc_q;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_port_enable: assert property (
        reg_wr_en && reg_addr == CIC_ADDR_AICTRL
        |=> ad_port_oe == $past(reg_wdata[CIC_PORT_EN_BIT]))
        else $error("port enable not taken from write");
    chk_clock_select: assert property (
        reg_wr_en && reg_addr == CIC_ADDR_AICTRL
        |=> converter_clock_sel == $past(reg_wdata[CIC_CLK_SEL_BIT]))
        else $error("clock select not taken from write");
    chk_clamp_mode: assert property (
        clamp_reference_sel |-> !clamp_follow_noise)
        else $error("clamp follows noise in reference mode");
    chk_gain_reset_edge: assert property (
        ctrl_q[CIC_SWIND_BIT] && sw_seen_q
        && $changed(source_switch_indicator) |=> gain_loop_reset)
        else $error("edge did not reset gain loop");
    chk_gain_reset_off: assert property (
        !ctrl_q[CIC_SWIND_BIT] |=> !gain_loop_reset)
        else $error("gain reset while indicator disabled");
    chk_gain_ch3_word: assert property (
        reg_wr_en && reg_addr == CIC_ADDR_GAIN3
        |=> static_gain_ch3[7:0] == $past(reg_wdata))
        else $error("channel 3 gain low byte wrong");
    chk_gain_ch4_word: assert property (
        reg_wr_en && reg_addr == CIC_ADDR_AICTRL
        |=> static_gain_ch4[8] == $past(reg_wdata[CIC_G4_MSB_BIT]))
        else $error("channel 4 gain msb wrong");
    chk_fast_select: assert property (
        v1_q && dsw_q[CIC_FSW_EN_BIT] |=> out_is_comp
        == ($past(fs_if.rdata[0]) ^ $past(dsw_q[CIC_FSW_POL_BIT])))
        else $error("fast switch mapping wrong");
    chk_static_select: assert property (
        v1_q && !dsw_q[CIC_FSW_EN_BIT]
        |=> out_is_comp == $past(dsw_q[CIC_FSW_POL_BIT]))
        else $error("static source selection wrong");
    chk_valid_latency: assert property (
        pix_valid |-> ##2 out_valid)
        else $error("output valid latency wrong");

    cov_fast_switch: cover property (
        dsw_q[CIC_FSW_EN_BIT] && out_valid && out_is_comp);
    cov_gain_reset: cover property (gain_loop_reset);
    cov_peaking: cover property (
        dsw_q[CIC_PEAK_BIT] && out_valid && out_is_comp);
    cov_neg_delay: cover property (dsw_q[CIC_CPDL_HI] && out_valid);
endmodule

// file: tb/cic_src_model.sv
// pixel source model for the cvbs and component video sources
// assumes the bench raises run for a whole burst of pixels
module cic_src_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       run,
    output logic            pix_valid,
    output logic      [7:0] cvbs_pix,
    output logic      [7:0] comp_pix,
    output logic            fast_switch_input
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] seq_q;
    // sources locked
    // one counter feeds both sources, so component stays synchronous
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seq_q <= '0;
            pix_valid <= 1'b0;
            cvbs_pix <= '0;
            comp_pix <= '0;
            fast_switch_input <= 1'b0;
        end else if (run) begin
            pix_valid <= 1'b1;
            cvbs_pix <= seq_q[7:0];
            comp_pix <= seq_q[7:0] + 8'h80;
            fast_switch_input <= seq_q[2] ^ seq_q[4];
            seq_q <= seq_q + 16'h0001;
        end else begin
            // idle lines toggle so stale data never passes for a pixel
            pix_valid <= 1'b0;
            cvbs_pix <= ~cvbs_pix;
            comp_pix <= ~comp_pix;
            fast_switch_input <= ~fast_switch_input;
            seq_q <= '0;
        end
    end
endmodule

// file: tb/cic_top_tb.sv
// self-checking bench of the component input control block
// assumes the source model and the design's assertions alongside
module cic_top_tb
    import cic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk;
    logic       rst;
    logic       reg_wr_en;
    logic       reg_rd_en;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [7:0] adc_sample;
    logic [7:0] ad_port_out;
    logic       ad_port_oe;
    logic       converter_clock_sel;
    logic       clamp_reference_sel;
    logic       line_noise_clamp_setting;
    logic       clamp_follow_noise;
    logic       source_switch_indicator;
    logic       gain_loop_reset;
    logic [8:0] static_gain_ch3;
    logic [8:0] static_gain_ch4;
    logic       pix_valid;
    logic [7:0] cvbs_pix;
    logic [7:0] comp_pix;
    logic       fast_switch_input;
    logic [7:0] out_pix;
    logic       out_valid;
    logic       out_is_comp;
    logic       run;
    int         mismatches;
    int         check_count;
    int         cycles;
    // the pad as seen from outside: released pins float
    wire  [7:0] ad_wire = ad_port_oe ? ad_port_out : 8'hzz;

    cic_top cic_top_i (.*);
    cic_src_model cic_src_model_i (.*);

    always #4 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic final_report();
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        #1;
        chk(9'(reg_rdata), 9'(e));
    endtask

    function automatic int sx(input int v, input int w);
        return (v >= (1 << (w - 1))) ? v - (1 << w) : v;
    endfunction

    function automatic int pk(input int i);
        int v;
        v = (i + 128) % 256;
        v = v + v / 4 - ((i + 127) % 256) / 4;
        return (v < 0) ? 0 : ((v > 255) ? 255 : v);
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk(9'(ad_wire), 9'(8'hzz));
        chk(static_gain_ch3, 9'h000);
        rd(CIC_ADDR_DSW, 8'h00);
    endtask

    task automatic t_ctrl();
        @(posedge clk);
        line_noise_clamp_setting <= 1'b1;
        adc_sample <= 8'hA5;
        wr(CIC_ADDR_AICTRL, 8'hFF);
        rd(CIC_ADDR_AICTRL, 8'hF7);
        // unmapped read must replace the F7 still standing on reg_rdata
        rd(8'h30, 8'h00);
        chk(9'(ad_wire), 9'h0A5);
        chk(9'(converter_clock_sel), 9'h001);
        chk(9'(clamp_follow_noise), 9'h000);
        chk(9'(clamp_reference_sel), 9'h001);
        chk(static_gain_ch4, 9'h100);
        wr(CIC_ADDR_AICTRL, 8'h00);
        tick(1);
        chk(9'(ad_wire), 9'(8'hzz));
        chk(9'(converter_clock_sel), 9'h000);
        chk(9'(clamp_follow_noise), 9'h001);
        chk(9'(clamp_reference_sel), 9'h000);
    endtask

    task automatic t_gain();
        wr(CIC_ADDR_AICTRL, 8'h02);
        wr(CIC_ADDR_GAIN3, 8'h90);
        wr(CIC_ADDR_GAIN4, 8'hFF);
        tick(1);
        chk(static_gain_ch3, 9'h090);
        chk(static_gain_ch4, 9'h1FF);
        wr(CIC_ADDR_AICTRL, 8'h01);
        tick(1);
        chk(static_gain_ch3, 9'h190);
        chk(static_gain_ch4, 9'h0FF);
    endtask

    task automatic t_swind(input logic en);
        int n;
        wr(CIC_ADDR_AICTRL, {5'h00, en, 2'h0});
        for (int e = 0; e < 2; e++) begin
            n = 0;
            @(posedge clk);
            source_switch_indicator <= ~source_switch_indicator;
            repeat (4) begin
                tick(1);
                n += int'(gain_loop_reset === 1'b1);
            end
            chk(9'(n), {8'h00, en});
        end
    endtask

    task automatic t_pix(input logic [7:0] cfg);
        int k;
        int dc;
        int df;
        int sel;
        int ev;
        k = 0;
        dc = 19 + 4 * sx(int'(cfg[2:0]), 3);
        df = dc + sx(int'(cfg[5:4]), 2);
        wr(CIC_ADDR_DSW, cfg);
        @(posedge clk);
        run <= 1'b1;
        repeat (80) begin
            tick(1);
            if (out_valid === 1'b1) begin
                sel = cfg[7] ? (((k - df) >> 2 ^ (k - df) >> 4) & 1) : 0;
                sel = sel ^ int'(cfg[6]);
                ev = (k - dc + 128) % 256;
                ev = (sel == 0) ? (k - 19) % 256 : (cfg[3] ? pk(k - dc) : ev);
                if (k >= 40) begin
                    chk(9'(out_is_comp), 9'(sel));
                    chk(9'(out_pix), 9'(ev));
                end
                k++;
            end
        end
        // 78 of the 80 pixels in the window must come out, two clocks behind
        chk(9'(k), 9'h04E);
        @(posedge clk);
        run <= 1'b0;
        tick(4);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    logic [7:0] cfgs [11] = '{8'h00, 8'h40, 8'h44, 8'h43, 8'h4C, 8'h80,
                              8'hC0, 8'h90, 8'hA0, 8'hB0, 8'hB5};

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        adc_sample = 8'h00;
        line_noise_clamp_setting = 1'b0;
        source_switch_indicator = 1'b0;
        run = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        t_reset();
        t_ctrl();
        t_gain();
        t_swind(1'b1);
        t_swind(1'b0);
        foreach (cfgs[i]) begin
            t_pix(cfgs[i]);
        end
        // a second reset mid-run, with the gain and DSW registers no longer at zero
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        t_reset();
        final_report();
    end
endmodule
